// ===== hdl/mii_smi_source_select.sv
// mii clock, management and data port source select with config register
// assumes CLK at 250 mhz, pins and phy clocks asynchronous to it, and that
// software quiets the mac before rewriting the config register
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`include "mii_sel_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module mii_smi_source_select (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [`ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [`DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [`DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic INT_RX_CLK,
  input wire logic INT_TX_CLK,
  input wire logic EXT_RX_CLK,
  input wire logic EXT_TX_CLK,
  output logic MAC_RX_CLK,
  output logic MAC_TX_CLK,
  input wire mii_sel_pkg::mii_tx_t MAC_TX,
  output mii_sel_pkg::mii_tx_t INT_TX,
  output mii_sel_pkg::mii_tx_t EXT_TX,
  input wire mii_sel_pkg::mii_rx_t INT_RX,
  input wire mii_sel_pkg::mii_rx_t EXT_RX,
  output mii_sel_pkg::mii_rx_t MAC_RX,
  input wire logic MAC_MDC,
  input wire logic MAC_MDIO_O,
  input wire logic MAC_MDIO_OE,
  output logic MAC_MDIO_I,
  output logic INT_MDC,
  output logic INT_MDIO_O,
  output logic INT_MDIO_OE,
  input wire logic INT_MDIO_I,
  output logic EXT_MDC,
  output logic EXT_MDIO_O,
  output logic EXT_MDIO_OE,
  input wire logic EXT_MDIO_I
);
  import mii_sel_pkg::*;

  // synchroniser vector: four clocks, outside rx bundle, outside mdio
  localparam int SW = 4 + $bits(mii_rx_t) + 1;
  logic [SW-1:0] async_in;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic int_rx_clk_s;
  logic int_tx_clk_s;
  logic ext_rx_clk_s;
  logic ext_tx_clk_s;
  mii_rx_t ext_rx_s;
  logic ext_mdio_s;
  logic [1:0] clk_sel_q;
  logic mgmt_sel_q;
  logic port_en_q;
  logic strap_q;
  logic strap_done_q;
  logic [1:0] strap_cnt_q;
  clk_src_t clk_src;
  bus_state_t bus_q;
  logic wait_q;
  logic [`DATA_W-1:0] rdata_q;
  logic [`DATA_W-1:0] cfg_view;
  logic bus_req;
  logic cfg_hit;
  logic wr_take;
  logic mac_rx_clk_q;
  logic mac_tx_clk_q;
  mii_tx_t int_tx_q;
  mii_tx_t ext_tx_q;
  mii_rx_t mac_rx_q;
  logic mac_mdio_i_q;
  logic int_mdc_q;
  logic int_mdio_o_q;
  logic int_mdio_oe_q;
  logic ext_mdc_q;
  logic ext_mdio_o_q;
  logic ext_mdio_oe_q;
  assign async_in = {INT_RX_CLK, INT_TX_CLK, EXT_RX_CLK, EXT_TX_CLK,
                     EXT_RX, EXT_MDIO_I};

  // two flops per bit; only the second stage is read anywhere
  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++)
    begin : g_sync
      always_ff @(posedge CLK or posedge RST)
      begin
        if (RST)
        begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end
        else if (CE)
        begin
          sync1_q[gi] <= async_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate
  assign {int_rx_clk_s, int_tx_clk_s, ext_rx_clk_s, ext_tx_clk_s,
          ext_rx_s, ext_mdio_s} = sync2_q;
  // avalon slave: one wait cycle, then a single-cycle acknowledge
  assign bus_req = AVS_READ | AVS_WRITE;
  assign cfg_hit = (AVS_ADDRESS == `CFG_REG_ADDR);
  assign wr_take = AVS_WRITE && bus_q == BUS_ACK && cfg_hit
                   && AVS_BYTEENABLE[0];

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      bus_q <= BUS_IDLE;
      wait_q <= 1'b1;
    end
    else if (CE)
    begin
      unique case (bus_q)
        BUS_IDLE:
        begin
          if (bus_req)
          begin
            bus_q <= BUS_ACK;
            wait_q <= 1'b0;
          end
        end
        BUS_ACK:
        begin
          bus_q <= BUS_IDLE;
          wait_q <= 1'b1;
        end
      endcase
    end
  end

  // reserved and unmapped bits read zero
  always_comb
  begin
    cfg_view = `RD_UNMAPPED;
    cfg_view[`CLK_SEL_MSB:`CLK_SEL_LSB] = clk_sel_q;
    cfg_view[`MGMT_SEL_BIT] = mgmt_sel_q;
    cfg_view[`STRAP_BIT] = strap_q;
    cfg_view[`PORT_EN_BIT] = port_en_q;
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      rdata_q <= `RD_UNMAPPED;
    else if (CE && bus_q == BUS_IDLE && AVS_READ)
      rdata_q <= cfg_hit ? cfg_view : `RD_UNMAPPED;
  end

  // writes while the mac runs would glitch its clocks; software must
  // stop it first, nothing here guards against that
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      clk_sel_q <= `CLK_SEL_RST;
      mgmt_sel_q <= `MGMT_SEL_RST;
      port_en_q <= `PORT_EN_RST;
    end
    else if (CE && wr_take)
    begin
      clk_sel_q <= AVS_WRITEDATA[`CLK_SEL_MSB:`CLK_SEL_LSB];
      mgmt_sel_q <= AVS_WRITEDATA[`MGMT_SEL_BIT];
      port_en_q <= AVS_WRITEDATA[`PORT_EN_BIT];
    end
  end

  // strap taken once the synchroniser holds post-reset pin levels
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
      strap_q <= 1'b0;
    end
    else if (CE && !strap_done_q)
    begin
      if (strap_cnt_q == `STRAP_WAIT)
      begin
        strap_q <= ext_mdio_s;
        strap_done_q <= 1'b1;
      end
      else
        strap_cnt_q <= strap_cnt_q + 2'h1;
    end
  end

  // clock source decode; only the select field feeds it
  always_comb
  begin
    unique case (clk_sel_q)
      `CLK_SEL_EXT: clk_src = SRC_EXT;
      `CLK_SEL_OFF: clk_src = SRC_OFF;
      default: clk_src = SRC_INT;
    endcase
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      mac_rx_clk_q <= 1'b0;
      mac_tx_clk_q <= 1'b0;
    end
    else if (CE)
    begin
      unique case (clk_src)
        SRC_INT:
        begin
          mac_rx_clk_q <= int_rx_clk_s;
          mac_tx_clk_q <= int_tx_clk_s;
        end
        SRC_EXT:
        begin
          mac_rx_clk_q <= ext_rx_clk_s;
          mac_tx_clk_q <= ext_tx_clk_s;
        end
        default:
        begin
          mac_rx_clk_q <= 1'b0;
          mac_tx_clk_q <= 1'b0;
        end
      endcase
    end
  end

  // data port steered by the enable alone
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      int_tx_q <= '0;
      ext_tx_q <= '0;
      mac_rx_q <= '0;
    end
    else if (CE)
    begin
      if (port_en_q)
      begin
        int_tx_q <= '0;
        ext_tx_q <= MAC_TX;
        mac_rx_q <= ext_rx_s;
      end
      else
      begin
        int_tx_q <= MAC_TX;
        ext_tx_q <= '0;
        mac_rx_q <= INT_RX;
      end
    end
  end

  // management port steered by its select alone
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      int_mdc_q <= 1'b0;
      int_mdio_o_q <= 1'b0;
      int_mdio_oe_q <= 1'b0;
      ext_mdc_q <= 1'b0;
      ext_mdio_o_q <= 1'b0;
      ext_mdio_oe_q <= 1'b0;
      mac_mdio_i_q <= 1'b0;
    end
    else if (CE)
    begin
      if (mgmt_sel_q)
      begin
        int_mdc_q <= 1'b0;
        int_mdio_o_q <= 1'b0;
        int_mdio_oe_q <= 1'b1;
        ext_mdc_q <= MAC_MDC;
        ext_mdio_o_q <= MAC_MDIO_O;
        ext_mdio_oe_q <= MAC_MDIO_OE;
        mac_mdio_i_q <= ext_mdio_s;
      end
      else
      begin
        int_mdc_q <= MAC_MDC;
        int_mdio_o_q <= MAC_MDIO_O;
        int_mdio_oe_q <= MAC_MDIO_OE;
        ext_mdc_q <= 1'b0;
        ext_mdio_o_q <= 1'b0;
        ext_mdio_oe_q <= 1'b0;
        mac_mdio_i_q <= INT_MDIO_I;
      end
    end
  end

  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign MAC_RX_CLK = mac_rx_clk_q;
  assign MAC_TX_CLK = mac_tx_clk_q;
  assign INT_TX = int_tx_q;
  assign EXT_TX = ext_tx_q;
  assign MAC_RX = mac_rx_q;
  assign MAC_MDIO_I = mac_mdio_i_q;
  assign INT_MDC = int_mdc_q;
  assign INT_MDIO_O = int_mdio_o_q;
  assign INT_MDIO_OE = int_mdio_oe_q;
  assign EXT_MDC = ext_mdc_q;
  assign EXT_MDIO_O = ext_mdio_o_q;
  assign EXT_MDIO_OE = ext_mdio_oe_q;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  clk_off_a: assert property (
    CE && clk_sel_q == `CLK_SEL_OFF |=> !MAC_RX_CLK && !MAC_TX_CLK)
    else $error("mac clocks toggle while disabled");
  clk_ext_a: assert property (
    CE && clk_sel_q == `CLK_SEL_EXT
    |=> MAC_RX_CLK == $past(ext_rx_clk_s)
        && MAC_TX_CLK == $past(ext_tx_clk_s))
    else $error("mac clocks not from outside port");
  clk_int_a: assert property (
    CE && clk_sel_q[0] == clk_sel_q[1]
    |=> MAC_RX_CLK == $past(int_rx_clk_s)
        && MAC_TX_CLK == $past(int_tx_clk_s))
    else $error("mac clocks not from internal phy");
  mgmt_int_a: assert property (
    CE && !mgmt_sel_q
    |=> !EXT_MDIO_OE && !EXT_MDC && INT_MDC == $past(MAC_MDC)
        && MAC_MDIO_I == $past(INT_MDIO_I))
    else $error("management not on internal phy");
  mgmt_ext_a: assert property (
    CE && mgmt_sel_q
    |=> !INT_MDC && INT_MDIO_OE && !INT_MDIO_O
        && EXT_MDIO_OE == $past(MAC_MDIO_OE))
    else $error("management not on outside phy");
  port_off_a: assert property (
    CE && !port_en_q |=> EXT_TX == '0 && INT_TX == $past(MAC_TX))
    else $error("outside port active while disabled");
  strap_hold_a: assert property (
    strap_done_q |=> strap_done_q && $stable(strap_q))
    else $error("strap changed after capture");
  strap_take_a: assert property (
    $fell(RST) |-> ##[3:300] strap_done_q)
    else $error("strap not captured after reset");
  cfg_write_a: assert property (
    CE && wr_take
    |=> port_en_q == $past(AVS_WRITEDATA[`PORT_EN_BIT])
        && clk_sel_q == $past(AVS_WRITEDATA[`CLK_SEL_MSB:`CLK_SEL_LSB]))
    else $error("config write lost");
  bus_ack_a: assert property (
    CE && bus_req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("no acknowledge after request");
  // read data carry the strap as it stood at the taking edge
  strap_read_a: assert property (
    CE && AVS_READ && AVS_WAITREQUEST && cfg_hit
    |=> AVS_READDATA[`STRAP_BIT] == $past(strap_q))
    else $error("strap readback wrong");

endmodule // mii_smi_source_select

`default_nettype wire

// ===== hdl/mii_sel_consts.svh
// offsets, field positions, reset values and codes of the mii source select
// assumes a 32-bit avalon-mm slave with byte addresses
//
// How it works
// - two-bit clock select, reset 00, picks source
// - clock select never touches management or data
// - management select routes transactions internal or outside
// - management select independent of port enable
// - management outside: internal mdio and mdc low
// - management internal: outside mdio released, mdc low
// - mdio strap sampled at every reset, held
// - strap reads one when mdio high, else zero
// - strap value only reported, steers nothing
// - port enable bit read-write, reset zero
// - port enable zero: internal phy, outside disabled
// - port enable never touches management or clocks
`ifndef MII_SEL_CONSTS_SVH
`define MII_SEL_CONSTS_SVH

`define ADDR_W 8
`define DATA_W 32
`define CFG_REG_ADDR 8'h74
`define CLK_SEL_LSB 5
`define CLK_SEL_MSB 6
`define MGMT_SEL_BIT 4
`define STRAP_BIT 3
`define PORT_EN_BIT 2
`define CLK_SEL_RST 2'h0
`define MGMT_SEL_RST 1'h0
`define PORT_EN_RST 1'h0
`define CLK_SEL_INT0 2'h0
`define CLK_SEL_EXT 2'h1
`define CLK_SEL_OFF 2'h2
`define CLK_SEL_INT1 2'h3
`define STRAP_WAIT 2'h2
`define RD_UNMAPPED 32'h0

`endif

// ===== hdl/mii_sel_pkg.sv
// types shared by the mii source select and its bench
// assumes nothing beyond the constants header
package mii_sel_pkg;
  typedef struct packed {
    logic en;
    logic er;
    logic [3:0] d;
  } mii_tx_t;
  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] d;
  } mii_rx_t;
  typedef enum logic [1:0] {SRC_INT, SRC_EXT, SRC_OFF} clk_src_t;
  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;
endpackage

// ===== dv/mii_phy_model.sv
// far-side phys: free-running mii clocks and the outside mdio wire
// assumes the bench sets the strap pull level before reset
`timescale 1ns/1ps
`default_nettype none
module mii_phy_model (
  input wire logic pull,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  output logic mdio_i,
  output logic int_clk,
  output logic ext_clk
);
  initial int_clk = 1'b0;
  initial ext_clk = 1'b0;
  // rates differ so the source shows in the edge count
  always #40 int_clk = ~int_clk;
  always #24 ext_clk = ~ext_clk;
  // released wire settles to the strap resistor
  assign mdio_i = mdio_oe ? mdio_o : pull;
endmodule // mii_phy_model
`default_nettype wire

// ===== dv/test_mii_smi_source_select.sv
// self-checking bench for the mii source select
// assumes the design header, package and the phy model
`include "mii_sel_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module test_mii_smi_source_select;
  import mii_sel_pkg::*;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic CE = 1'b1;
  logic [7:0] AVS_ADDRESS = 8'h0;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0] AVS_BYTEENABLE = 4'hf;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic INT_CLK, EXT_CLK, MAC_RX_CLK, MAC_TX_CLK;
  mii_tx_t MAC_TX = '0;
  mii_tx_t INT_TX, EXT_TX;
  mii_rx_t INT_RX = '0;
  mii_rx_t EXT_RX = '0;
  mii_rx_t MAC_RX;
  logic MAC_MDC = 1'b0;
  logic MAC_MDIO_O = 1'b0;
  logic MAC_MDIO_OE = 1'b0;
  logic INT_MDIO_I = 1'b0;
  logic MAC_MDIO_I, INT_MDC, INT_MDIO_O, INT_MDIO_OE;
  logic EXT_MDC, EXT_MDIO_O, EXT_MDIO_OE, EXT_MDIO_I;
  logic pull = 1'b1;
  logic [31:0] seed = 32'h0000ade9;
  logic [31:0] q;
  int n_mismatch = 0;
  int num_checks = 0;

  mii_smi_source_select mii_smi_source_select_inst (
    .CLK, .RST, .CE, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
    .INT_RX_CLK(INT_CLK), .INT_TX_CLK(INT_CLK), .EXT_RX_CLK(EXT_CLK),
    .EXT_TX_CLK(EXT_CLK), .MAC_RX_CLK, .MAC_TX_CLK, .MAC_TX, .INT_TX,
    .EXT_TX, .INT_RX, .EXT_RX, .MAC_RX, .MAC_MDC, .MAC_MDIO_O,
    .MAC_MDIO_OE, .MAC_MDIO_I, .INT_MDC, .INT_MDIO_O, .INT_MDIO_OE,
    .INT_MDIO_I, .EXT_MDC, .EXT_MDIO_O, .EXT_MDIO_OE, .EXT_MDIO_I
  );
  mii_phy_model mii_phy_model_inst (
    .pull(pull), .mdio_o(EXT_MDIO_O), .mdio_oe(EXT_MDIO_OE),
    .mdio_i(EXT_MDIO_I), .int_clk(INT_CLK), .ext_clk(EXT_CLK)
  );

  always #2 CLK = ~CLK;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] exp_rd(input logic [31:0] c,
                                         input logic s);
    return (c & 32'h00000074) | {28'h0, s, 3'h0};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask

  task automatic route(input logic [31:0] c);
    logic [31:0] r;
    int n;
    int x;
    int e;
    logic last;
    r = rnd();
    MAC_TX <= mii_tx_t'(r[5:0]);
    INT_RX <= mii_rx_t'(r[11:6]);
    EXT_RX <= mii_rx_t'(r[17:12]);
    {MAC_MDC, MAC_MDIO_O, MAC_MDIO_OE, INT_MDIO_I} <= r[21:18];
    repeat (5) @(posedge CLK);
    chk({INT_MDC, INT_MDIO_O, INT_MDIO_OE}, c[4] ? 3'h1 :
        {MAC_MDC, MAC_MDIO_O, MAC_MDIO_OE});
    chk({EXT_MDC, EXT_MDIO_OE, EXT_MDIO_O}, c[4] ?
        {MAC_MDC, MAC_MDIO_OE, MAC_MDIO_O} : 3'h0);
    chk(MAC_MDIO_I, c[4] ? EXT_MDIO_I : INT_MDIO_I);
    chk({INT_TX, EXT_TX}, c[2] ? {6'h0, MAC_TX} : {MAC_TX, 6'h0});
    chk(MAC_RX, c[2] ? EXT_RX : INT_RX);
    n = 0;
    x = 0;
    last = MAC_RX_CLK;
    // 960 ns: 20 outside edges, 12 internal, none when off
    repeat (240)
    begin
      @(posedge CLK);
      if (MAC_RX_CLK === 1'b1 && last === 1'b0)
        n++;
      if (MAC_TX_CLK !== MAC_RX_CLK)
        x++;
      last = MAC_RX_CLK;
    end
    e = c[6:5] == 2'h1 ? 20 : c[6:5] == 2'h2 ? 0 : 12;
    if (e > 0 && n >= e - 1 && n <= e + 1)
      n = e;
    chk(n, e);
    chk(x, 0);
    // clock enable low: the routed data must hold its last value
    r[5:0] = MAC_TX;
    CE <= 1'b0;
    MAC_TX <= mii_tx_t'(~r[5:0]);
    repeat (4) @(posedge CLK);
    chk({INT_TX, EXT_TX}, c[2] ? {6'h0, r[5:0]} : {r[5:0], 6'h0});
    CE <= 1'b1;
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    logic [31:0] c;
    logic [31:0] k;
    // strap pulled high on the first reset, low on the second
    for (int p = 1; p >= 0; p--)
    begin
      pull <= p[0];
      RST <= 1'b1;
      repeat (20) @(posedge CLK);
      RST <= 1'b0;
      repeat (4) @(posedge CLK);
      bus(1'b0, 8'h74, 32'h0, 4'hf);
      chk(q, exp_rd(32'h0, pull));
      k = 32'h0;
      route(k);
      for (int i = 0; i < 8; i++)
      begin
        c = rnd();
        c[6:5] = i[1:0];
        MAC_TX <= '0;
        bus(1'b1, 8'h74, c, 4'hf);
        bus(1'b0, 8'h74, 32'h0, 4'hf);
        chk(q, exp_rd(c, pull));
        k = c;
        route(k);
        $display("test %0d.%0d done", p, i);
      end
      // refused: lane 0 off, unmapped write, unmapped read
      bus(1'b1, 8'h74, ~k, 4'he);
      bus(1'b1, 8'h70, ~k, 4'hf);
      bus(1'b0, 8'h70, 32'h0, 4'hf);
      chk(q, 32'h0);
      bus(1'b0, 8'h74, 32'h0, 4'hf);
      chk(q, exp_rd(k, pull));
    end
    end_sim();
  end

  initial
  begin
    #100000;
    n_mismatch++;
    end_sim();
  end
endmodule // test_mii_smi_source_select
`default_nettype wire
